// [testbench/dugm_remote.sv]
// contact-closure remote model driving the parallel inputs, with contact bounce
`timescale 1ns/1ps
`default_nettype none
module dugm_remote (
    // clock
    input wire logic clk,
    // closures requested by the bench
    input wire logic [7:0] close_cmd,
    // contact levels at the pins
    output var logic [7:0] gpio_in = 8'h00
);
    logic [7:0] prev = 8'h00;
    logic [3:0] chatter = 4'h0;
    // a real contact chatters after every change, so the pins flip before settling
    always_ff @(posedge clk) begin
        prev <= close_cmd;
        if (close_cmd != prev) begin
            chatter <= 4'h8;
        end else if (chatter != 4'h0) begin
            chatter <= chatter - 4'h1;
        end
        gpio_in <= (chatter[0] && chatter != 4'h0) ? ~close_cmd : close_cmd;
    end
endmodule
`default_nettype wire

// [testbench/test_dugm_gpio_mapper.sv]
// self-checking bench for the gpio mapper
`timescale 1ns/1ps
`default_nettype none
`include "dugm_params.svh"
module test_dugm_gpio_mapper;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] gpio_in, gpio_out, mark_cue, mark_flag;
    logic [7:0] close_cmd = 8'h00;
    logic build_press, exit_press, dump_press, bypass_press, cough_hold, pause_hold;
    logic [3:0] lamp_lit = 4'h0, lamp_flash = 4'h0;
    logic flash_phase = 1'b0, st_building = 1'b0, st_exiting = 1'b0, delay_at_maximum = 1'b0;
    logic dump_increment_met = 1'b0, delay_memory_empty = 1'b0, button_held = 1'b0;
    logic bypass_on = 1'b0, dump_event = 1'b0, in_sample_stb = 1'b0, out_sample_stb = 1'b0;
    logic splice_stb = 1'b0;
    logic [7:0] out_cue = 8'h00, out_flag = 8'h00, splice_cue = 8'h00, splice_flag = 8'h00;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    logic [31:0] rv;

    dugm_gpio_mapper #(.CYCLES_PER_MS(10)) dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .gpio_in, .gpio_out, .build_press, .exit_press,
        .dump_press, .bypass_press, .cough_hold, .pause_hold, .lamp_lit, .lamp_flash, .flash_phase,
        .st_building, .st_exiting, .delay_at_maximum, .dump_increment_met, .delay_memory_empty,
        .button_held, .bypass_on, .dump_event, .in_sample_stb, .mark_cue, .mark_flag, .out_sample_stb,
        .out_cue, .out_flag, .splice_stb, .splice_cue, .splice_flag);
    dugm_remote remote_u (.clk(clk), .close_cmd(close_cmd), .gpio_in(gpio_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one avalon transfer; read data is taken at the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic pulse_len(input int b, output int len);
        int w;
        w = 0;
        len = 0;
        while (gpio_out[b] !== 1'b0 && w < 3000) begin
            @(negedge clk);
            w++;
        end
        while (gpio_out[b] === 1'b0 && len < 3000) begin
            @(negedge clk);
            len++;
        end
    endtask
    task automatic presses(input logic [7:0] c, output int cnt);
        @(posedge clk);
        close_cmd <= c;
        cnt = 0;
        repeat (300) begin
            @(negedge clk);
            if ((build_press | exit_press | dump_press | bypass_press) === 1'b1) cnt++;
        end
    endtask
    task automatic lvl(input int b, input logic e, input string what);
        repeat (3) @(negedge clk);
        chk(gpio_out[b], e, what);
        @(posedge clk);
    endtask
    task automatic strobe_cue(input int kind);
        @(posedge clk);
        out_cue <= 8'h01;
        out_flag <= 8'h01;
        splice_cue <= 8'h01;
        out_sample_stb <= (kind == 0);
        splice_stb <= (kind == 1);
        @(posedge clk);
        out_sample_stb <= 1'b0;
        splice_stb <= 1'b0;
    endtask

    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #3000000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        bus(0, `DUGM_OFS_CTRL, 0); chk(rv, 32'h0000_0001, "ctrl reset");
        bus(0, `DUGM_OFS_PULSE, 0); chk(rv, 32'h0000_00FA, "pulse reset");
        bus(0, 8'h10, 0); chk(rv, 32'h0000_0000, "unmapped read");
        bus(1, `DUGM_OFS_PULSE, 50); bus(0, `DUGM_OFS_PULSE, 0); chk(rv, 32'h0000_0064, "pulse min");
        bus(1, `DUGM_OFS_PULSE, 2000); bus(0, `DUGM_OFS_PULSE, 0); chk(rv, 32'h0000_03E8, "pulse max");
        bus(1, `DUGM_OFS_PULSE, 100);
        // pins 0 and 1 both carry the build function
        bus(1, 8'h20, 1);
        bus(1, 8'h24, 1);
        presses(8'h01, n); chk(n, 1, "press pin0");
        presses(8'h00, n); chk(n, 0, "release pin0");
        presses(8'h02, n); chk(n, 1, "press pin1");
        presses(8'h00, n);
        bus(1, `DUGM_OFS_CTRL, 0);
        presses(8'h01, n); chk(n, 0, "press disabled");
        presses(8'h00, n);
        bus(1, `DUGM_OFS_CTRL, 1);
        bus(1, 8'h40, 1);
        st_building <= 1'b1;
        pulse_len(0, n); chk(n, 1000, "build pulse len");
        lvl(0, 1'b1, "build pulse once");
        bus(1, 8'h44, 8'h09);
        lamp_lit <= 4'h1; lvl(1, 1'b0, "lamp lit");
        lamp_lit <= 4'h0; lvl(1, 1'b1, "lamp dark");
        bus(1, 8'h48, 8'h2A);
        delay_at_maximum <= 1'b1; lvl(2, 1'b0, "at max");
        delay_at_maximum <= 1'b0; lvl(2, 1'b1, "below max");
        bus(1, 8'h48, 8'h4A); lvl(2, 1'b0, "unmet");
        dump_increment_met <= 1'b1; lvl(2, 1'b1, "met");
        bus(1, 8'h48, 8'h7A); lvl(2, 1'b0, "dump ready");
        bus(1, 8'h48, 8'h6A);
        button_held <= 1'b1;
        delay_memory_empty <= 1'b1; lvl(2, 1'b0, "muted");
        button_held <= 1'b0; lvl(2, 1'b1, "unmuted");
        bus(1, 8'h54, 8'h07);
        delay_at_maximum <= 1'b1;
        pulse_len(5, n); chk(n, 1000, "full pulse");
        bus(1, 8'h58, 8'h08);
        delay_memory_empty <= 1'b0;
        repeat (4) @(posedge clk);
        delay_memory_empty <= 1'b1;
        pulse_len(6, n); chk(n, 1000, "empty pulse");
        bus(1, 8'h28, 8'h09);
        bus(1, 8'h4C, 8'h06);
        presses(8'h04, n); lvl(3, 1'b0, "util closed");
        presses(8'h00, n); lvl(3, 1'b1, "util open");
        bus(1, 8'h2C, 8'h07);
        bus(1, 8'h50, 8'h04);
        bus(1, 8'h5C, 8'h05);
        // pins 4..7 carry flag, cough, pause and dump
        bus(1, 8'h30, 8'h08);
        bus(1, 8'h34, 8'h03);
        bus(1, 8'h38, 8'h06);
        bus(1, 8'h3C, 8'h04);
        presses(8'h08, n);
        presses(8'hF0, n); chk(n, 1, "dump press");
        chk(cough_hold, 1'b1, "cough held");
        chk(pause_hold, 1'b1, "pause held");
        @(posedge clk);
        in_sample_stb <= 1'b1;
        @(posedge clk);
        in_sample_stb <= 1'b0;
        @(negedge clk); chk(mark_cue, 8'h01, "cue tagged");
        chk(mark_flag, 8'h01, "flag tagged");
        strobe_cue(0);
        pulse_len(4, n); chk(n, 1000, "cue out pulse");
        chk(gpio_out[7], 1'b0, "flag out");
        strobe_cue(1);
        pulse_len(4, n); chk(n, 1000, "cue splice pulse");
        chk(gpio_out[7], 1'b1, "flag splice");
        bus(1, `DUGM_OFS_CTRL, 3);
        bus(1, `DUGM_OFS_TEST_OUT, 8'hA5);
        repeat (2) @(negedge clk); chk(gpio_out, 8'hA5, "test drive");
        bus(1, `DUGM_OFS_CTRL, 1);
        n = 0;
        repeat (6) begin
            @(negedge clk);
            if (gpio_out === 8'h00) n++;
        end
        chk(n, 1, "test exit zero");
        final_report();
    end
endmodule
`default_nettype wire

// [verilog/dugm_gpio_mapper.sv]
// gpio mapper: input functions, mark tagging, output drivers, avalon registers
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dugm_params.svh"
module dugm_gpio_mapper
    import dugm_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int NUM_MARKS = 8, // R12
    parameter int NUM_UTIL = 4,
    parameter int CYCLES_PER_MS = (`DUGM_TICK_NS + `DUGM_CLK_PERIOD_NS - 1) / `DUGM_CLK_PERIOD_NS,
    parameter int TIMER_W = 25
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // parallel pins
    input wire logic [NUM_PINS-1:0] gpio_in,
    output logic [NUM_PINS-1:0] gpio_out,
    // button actions towards the delay engine
    output logic build_press,
    output logic exit_press,
    output logic dump_press,
    output logic bypass_press,
    output logic cough_hold,
    output logic pause_hold,
    // engine status, same clock
    input wire logic [3:0] lamp_lit,
    input wire logic [3:0] lamp_flash,
    input wire logic flash_phase,
    input wire logic st_building,
    input wire logic st_exiting,
    input wire logic delay_at_maximum,
    input wire logic dump_increment_met,
    input wire logic delay_memory_empty,
    input wire logic button_held,
    input wire logic bypass_on,
    input wire logic dump_event,
    // marks entering the delay with each input sample
    input wire logic in_sample_stb,
    output logic [NUM_MARKS-1:0] mark_cue,
    output logic [NUM_MARKS-1:0] mark_flag,
    // marks leaving the delay, and marks of dumped audio at the splice
    input wire logic out_sample_stb,
    input wire logic [NUM_MARKS-1:0] out_cue,
    input wire logic [NUM_MARKS-1:0] out_flag,
    input wire logic splice_stb,
    input wire logic [NUM_MARKS-1:0] splice_cue,
    input wire logic [NUM_MARKS-1:0] splice_flag
);
    // ---------------- registers ----------------
    logic [1:0] ctrl;
    logic [9:0] pulse_ms;
    logic [NUM_PINS-1:0] test_value;
    logic [6:0] in_map [NUM_PINS];
    logic [6:0] out_map [NUM_PINS];
    logic ack;
    logic test_exit;
    wire logic enable = ctrl[`DUGM_CTRL_EN_BIT];
    wire logic test_mode = ctrl[`DUGM_CTRL_TEST_BIT];
    wire logic bus_req = avs_read | avs_write;
    wire logic do_write = avs_write & ~avs_waitrequest;
    wire logic [2:0] page = avs_address[7:5];
    wire logic [2:0] pin_sel = avs_address[4:2];
    wire logic hit_ctrl = avs_address == `DUGM_OFS_CTRL;
    wire logic hit_pulse = avs_address == `DUGM_OFS_PULSE;
    wire logic hit_test = avs_address == `DUGM_OFS_TEST_OUT;
    wire logic hit_status = avs_address == `DUGM_OFS_STATUS;
    wire logic hit_in = (page == `DUGM_IN_MAP_PAGE) && (avs_address[1:0] == 2'h0);
    wire logic hit_out = (page == `DUGM_OUT_MAP_PAGE) && (avs_address[1:0] == 2'h0);
    wire logic [9:0] wr_ms = avs_writedata[9:0];
    // out-of-range lengths are clamped, never stored raw
    wire logic [9:0] clamped_ms = (avs_writedata[31:10] != 22'h00_0000 || wr_ms > `DUGM_PULSE_MS_MAX)
        ? `DUGM_PULSE_MS_MAX : (wr_ms < `DUGM_PULSE_MS_MIN) ? `DUGM_PULSE_MS_MIN : wr_ms;
    logic [NUM_PINS-1:0] deb;
    wire logic [31:0] rd_mux =
        hit_ctrl ? {30'h0000_0000, ctrl} :
        hit_pulse ? {22'h00_0000, pulse_ms} :
        hit_test ? {24'h00_0000, test_value} :
        hit_status ? {16'h0000, gpio_out, deb} :
        hit_in ? {25'h000_0000, in_map[pin_sel]} :
        hit_out ? {25'h000_0000, out_map[pin_sel]} : 32'h0000_0000;

    // one wait cycle: request seen at edge 0, answered at edge 1
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= bus_req & avs_waitrequest & ~ack;
            avs_waitrequest <= ~(bus_req & avs_waitrequest & ~ack);
            if (avs_read & avs_waitrequest & ~ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `DUGM_CTRL_RST;
            pulse_ms <= `DUGM_PULSE_MS_RST;
            test_value <= `DUGM_TEST_OUT_RST;
            test_exit <= 1'b0;
        end else begin
            test_exit <= do_write & hit_ctrl & test_mode & ~avs_writedata[`DUGM_CTRL_TEST_BIT]; // R18
            if (do_write & hit_ctrl) begin
                ctrl <= avs_writedata[1:0];
            end
            if (do_write & hit_pulse) begin
                pulse_ms <= clamped_ms; // R3
            end
            if (do_write & hit_test) begin
                test_value <= avs_writedata[NUM_PINS-1:0];
            end
        end
    end

    // ---------------- millisecond timebase ----------------
    logic [15:0] ms_div;
    logic ms_tick;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_div <= 16'h0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= ms_div == 16'(CYCLES_PER_MS - 1);
            ms_div <= (ms_div == 16'(CYCLES_PER_MS - 1)) ? 16'h0000 : ms_div + 16'h0001;
        end
    end

    // ---------------- inputs ----------------
    logic [NUM_PINS-1:0] deb_prev;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] lvl;
    logic [NUM_MARKS-1:0] cue_rise_pin [NUM_PINS];
    logic [NUM_MARKS-1:0] flag_lvl_pin [NUM_PINS];
    logic [NUM_UTIL-1:0] util_lvl_pin [NUM_PINS];
    logic [NUM_PINS-1:0] is_build, is_exit, is_cough, is_dump, is_bypass, is_pause;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_in
            logic meta, sync;
            logic [2:0] stable;
            wire logic [3:0] cls = in_map[gi][`DUGM_MAP_CLS_MSB:0];
            wire logic [2:0] idx = in_map[gi][`DUGM_MAP_IDX_MSB:`DUGM_MAP_IDX_LSB];
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    in_map[gi] <= `DUGM_MAP_RST;
                    meta <= 1'b0;
                    sync <= 1'b0;
                    stable <= 3'h0;
                    deb[gi] <= 1'b0;
                    deb_prev[gi] <= 1'b0;
                end else begin
                    if (do_write & hit_in & (pin_sel == 3'(gi))) begin
                        in_map[gi] <= avs_writedata[6:0];
                    end
                    meta <= gpio_in[gi]; // R22
                    sync <= meta;
                    deb_prev[gi] <= deb[gi];
                    // a level must hold for several ms ticks before it is believed
                    if (sync == deb[gi]) begin
                        stable <= 3'h0;
                    end else if (ms_tick) begin
                        if (stable == `DUGM_DEBOUNCE_MS) begin
                            deb[gi] <= sync; // R22
                            stable <= 3'h0;
                        end else begin
                            stable <= stable + 3'h1;
                        end
                    end
                end
            end
            assign rise[gi] = enable & deb[gi] & ~deb_prev[gi]; // R21 R22
            assign lvl[gi] = enable & deb[gi]; // R21
            assign is_build[gi] = cls == IC_BUILD;
            assign is_exit[gi] = cls == IC_EXIT;
            assign is_cough[gi] = cls == IC_COUGH;
            assign is_dump[gi] = cls == IC_DUMP;
            assign is_bypass[gi] = cls == IC_BYPASS;
            assign is_pause[gi] = cls == IC_PAUSE;
            assign cue_rise_pin[gi] = (rise[gi] && cls == IC_CUE) ? NUM_MARKS'(1) << idx : '0;
            assign flag_lvl_pin[gi] = (lvl[gi] && cls == IC_FLAG) ? NUM_MARKS'(1) << idx : '0;
            assign util_lvl_pin[gi] = (lvl[gi] && cls == IC_UTIL) ? NUM_UTIL'(1) << idx[1:0] : '0;
        end
    endgenerate

    // pins sharing a function are simply or-ed together
    logic [NUM_MARKS-1:0] cue_rise, flag_lvl;
    logic [NUM_UTIL-1:0] util_lvl;
    always_comb begin
        cue_rise = '0;
        flag_lvl = '0;
        util_lvl = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            cue_rise = cue_rise | cue_rise_pin[p]; // R20
            flag_lvl = flag_lvl | flag_lvl_pin[p];
            util_lvl = util_lvl | util_lvl_pin[p];
        end
    end

    logic [NUM_MARKS-1:0] cue_pend;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            build_press <= 1'b0;
            exit_press <= 1'b0;
            dump_press <= 1'b0;
            bypass_press <= 1'b0;
            cough_hold <= 1'b0;
            pause_hold <= 1'b0;
            cue_pend <= '0;
            mark_cue <= '0;
            mark_flag <= '0;
        end else begin
            build_press <= |(rise & is_build); // R1
            exit_press <= |(rise & is_exit); // R1
            dump_press <= |(rise & is_dump); // R1
            bypass_press <= |(rise & is_bypass); // R1
            cough_hold <= |(lvl & is_cough); // R1
            pause_hold <= |(lvl & is_pause); // R11
            // a closure arriving on the strobe cycle still rides that sample
            if (in_sample_stb) begin
                mark_cue <= cue_pend | cue_rise; // R13
                mark_flag <= flag_lvl; // R13 R16
                cue_pend <= '0;
            end else begin
                cue_pend <= cue_pend | cue_rise;
            end
        end
    end

    // ---------------- marks leaving the delay ----------------
    logic [NUM_MARKS-1:0] flag_out_lvl;
    logic building_q, full_q, empty_q;
    wire logic [NUM_MARKS-1:0] cue_hit = (out_sample_stb ? out_cue : '0) | (splice_stb ? splice_cue : '0); // R14 R15
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_out_lvl <= '0;
            building_q <= 1'b0;
            full_q <= 1'b0;
            empty_q <= 1'b0;
        end else begin
            if (out_sample_stb | splice_stb) begin
                flag_out_lvl <= (out_sample_stb ? out_flag : '0) | (splice_stb ? splice_flag : '0); // R14 R16
            end
            building_q <= st_building;
            full_q <= delay_at_maximum;
            empty_q <= delay_memory_empty;
        end
    end
    wire logic build_ev = st_building & ~building_q; // R2
    wire logic full_ev = delay_at_maximum & ~full_q; // R9
    wire logic empty_ev = delay_memory_empty & ~empty_q; // R9
    wire logic [7:0] state_vec = {dump_increment_met, button_held & delay_memory_empty, delay_memory_empty,
        ~dump_increment_met, dump_increment_met, delay_at_maximum, st_exiting, st_building}; // R5 R6 R7 R8 R10
    wire logic [3:0] lamp_now = (lamp_flash & {4{flash_phase}}) | (lamp_lit & ~lamp_flash);
    wire logic [TIMER_W-1:0] pulse_load = TIMER_W'(32'(pulse_ms) * CYCLES_PER_MS - 1);

    // ---------------- outputs ----------------
    logic [TIMER_W-1:0] timer [NUM_PINS];
    logic [NUM_PINS-1:0] pin_ev;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_out
            wire logic [3:0] cls = out_map[gi][`DUGM_MAP_CLS_MSB:0];
            wire logic [2:0] idx = out_map[gi][`DUGM_MAP_IDX_MSB:`DUGM_MAP_IDX_LSB];
            logic ev, is_pulse, active;
            always_comb begin
                ev = 1'b0;
                is_pulse = 1'b1;
                active = 1'b0;
                case (cls)
                    OC_BUILD_PULSE: ev = build_ev; // R2
                    OC_DUMP_PULSE: ev = dump_event; // R2
                    OC_CUE: ev = cue_hit[idx]; // R15
                    OC_FULL_PULSE: ev = full_ev; // R9
                    OC_EMPTY_PULSE: ev = empty_ev; // R9
                    OC_BYPASS: begin
                        is_pulse = 1'b0;
                        active = bypass_on;
                    end
                    OC_FLAG: begin
                        is_pulse = 1'b0;
                        active = flag_out_lvl[idx]; // R16
                    end
                    OC_UTIL: begin
                        is_pulse = 1'b0;
                        active = util_lvl[idx[1:0]]; // R17
                    end
                    OC_LAMP: begin
                        is_pulse = 1'b0;
                        active = lamp_now[idx[1:0]]; // R4
                    end
                    OC_STATE: begin
                        is_pulse = 1'b0;
                        active = state_vec[idx]; // R5
                    end
                    default: is_pulse = 1'b0;
                endcase
            end
            assign pin_ev[gi] = ev;
            wire logic next_out = test_exit ? 1'b0 : test_mode ? test_value[gi] :
                is_pulse ? ~(ev | (timer[gi] != '0)) : ~active;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    out_map[gi] <= `DUGM_MAP_RST;
                    timer[gi] <= '0;
                    gpio_out[gi] <= 1'b0;
                end else begin
                    if (do_write & hit_out & (pin_sel == 3'(gi))) begin
                        out_map[gi] <= avs_writedata[6:0];
                    end
                    // a new event reloads a running pulse instead of being dropped
                    if (test_exit) begin
                        timer[gi] <= '0; // R18
                    end else if (ev) begin
                        timer[gi] <= pulse_load; // R3 R23
                    end else if (timer[gi] != '0) begin
                        timer[gi] <= timer[gi] - TIMER_W'(1);
                    end
                    gpio_out[gi] <= next_out; // R19 R20
                end
            end
        end
    endgenerate

    // ---------------- checks ----------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic plain0 = !test_mode && !test_exit;

    property p_build_press;
        |(rise & is_build) |=> build_press;
    endproperty
    a_build_press: assert property (p_build_press) else $error("build input did not press build"); // R1
    property p_pulse_reload;
        pin_ev[0] && !test_exit |=> timer[0] == $past(pulse_load);
    endproperty
    a_pulse_reload: assert property (p_pulse_reload) else $error("pulse not (re)loaded"); // R23
    property p_pulse_range;
        pulse_ms >= `DUGM_PULSE_MS_MIN && pulse_ms <= `DUGM_PULSE_MS_MAX;
    endproperty
    a_pulse_range: assert property (p_pulse_range) else $error("pulse length out of range"); // R3
    // every pin is watched, since any pin may carry any function
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_chk
            wire logic [3:0] ocls = out_map[gi][`DUGM_MAP_CLS_MSB:0];
            wire logic [2:0] oidx = out_map[gi][`DUGM_MAP_IDX_MSB:`DUGM_MAP_IDX_LSB];
            property p_lamp;
                ocls == OC_LAMP && plain0 && lamp_lit[oidx[1:0]] && !lamp_flash[oidx[1:0]] |=> !gpio_out[gi];
            endproperty
            a_lamp: assert property (p_lamp) else $error("lit lamp mimic not low"); // R4
            property p_muted;
                ocls == OC_STATE && oidx == 3'h6 && plain0 && button_held && delay_memory_empty |=> !gpio_out[gi];
            endproperty
            a_muted: assert property (p_muted) else $error("muted output not low"); // R10
            property p_util;
                ocls == OC_UTIL && plain0 |=> gpio_out[gi] == !$past(util_lvl[oidx[1:0]]);
            endproperty
            a_util: assert property (p_util) else $error("utility not passed through"); // R17
            property p_cue_out;
                ocls == OC_CUE && cue_hit[oidx] && plain0 |=> !gpio_out[gi] [*2];
            endproperty
            a_cue_out: assert property (p_cue_out) else $error("cue mark gave no pulse"); // R15
            c_cue: cover property (ocls == OC_CUE && cue_hit[oidx] && plain0);
        end
    endgenerate
    property p_test_exit;
        test_exit |=> gpio_out == '0;
    endproperty
    a_test_exit: assert property (p_test_exit) else $error("outputs not zeroed on test exit"); // R18
    property p_disabled;
        !enable |=> !build_press && !dump_press && !exit_press && !bypass_press;
    endproperty
    a_disabled: assert property (p_disabled) else $error("input acted while disabled"); // R21
    property p_mark_tag;
        in_sample_stb |=> mark_cue == $past(cue_pend | cue_rise);
    endproperty
    a_mark_tag: assert property (p_mark_tag) else $error("cue not tagged to sample"); // R13
    property p_bus_answer;
        bus_req && avs_waitrequest && !ack |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered"); // R19
    c_test_exit: cover property (test_exit);
    c_build: cover property (build_press);
    c_retrigger: cover property (pin_ev[0] && timer[0] != '0);
endmodule
`default_nettype wire

// [verilog/dugm_params.svh]
// constants for the delay unit gpio mapper: offsets, fields, resets, timing
// Functional notes
// (R1) input button functions act like panel presses
// (R2) trigger outputs pulse once per state reach
// (R3) pulse length 100..1000 ms, default 250
// (R4) lamp mimic low lit, high dark, toggles
// (R5) state outputs held low while state holds
// (R6) dump ready once dump size reached
// (R7) unsafe indication while dump increment unmet
// (R8) delay full output while maximum reached
// (R9) trigger outputs on memory full and empty
// (R10) muted while button held and memory empty
// (R11) pause input suspends delay accumulation
// (R12) eight cues, eight flags, four utilities
// (R13) cue/flag attached to arriving audio sample
// (R14) dumped marks emitted at the splice
// (R15) cue reaching output gives one pulse
// (R16) flag output reproduces recorded input level
// (R17) utility channels pass through undelayed
// (R18) leaving test mode zeroes every output
// (R19) eight assignable inputs and eight outputs
// (R20) shared function behaves identically per pin
// (R21) global enable; disabled inputs are ignored
// (R22) inputs synchronised, debounced, edge acting
// (R23) retrigger restarts a running pulse
`ifndef DUGM_PARAMS_SVH
`define DUGM_PARAMS_SVH
`define DUGM_OFS_CTRL 8'h00
`define DUGM_OFS_PULSE 8'h04
`define DUGM_OFS_TEST_OUT 8'h08
`define DUGM_OFS_STATUS 8'h0C
`define DUGM_IN_MAP_PAGE 3'h1
`define DUGM_OUT_MAP_PAGE 3'h2
`define DUGM_CTRL_EN_BIT 0
`define DUGM_CTRL_TEST_BIT 1
`define DUGM_CTRL_RST 2'h1
`define DUGM_MAP_CLS_MSB 3
`define DUGM_MAP_IDX_LSB 4
`define DUGM_MAP_IDX_MSB 6
`define DUGM_MAP_RST 7'h00
`define DUGM_PULSE_MS_RST 10'h00FA
`define DUGM_PULSE_MS_MIN 10'h0064
`define DUGM_PULSE_MS_MAX 10'h03E8
`define DUGM_TEST_OUT_RST 8'h00
// 1 ms expressed in ns, and the clock period in ns
`define DUGM_TICK_NS 32'h000F_4240
`define DUGM_CLK_PERIOD_NS 32'h0000_0028
`define DUGM_DEBOUNCE_MS 3'h4
`endif

// [verilog/dugm_pkg.sv]
// types for the delay unit gpio mapper
package dugm_pkg;
    typedef enum logic [3:0] {
        IC_NONE, IC_BUILD, IC_EXIT, IC_COUGH, IC_DUMP, IC_BYPASS, IC_PAUSE, IC_CUE, IC_FLAG, IC_UTIL
    } dugm_in_cls_t;
    // lamp index: 0 build, 1 exit, 2 dump, 3 cough
    // state index: 0 building, 1 exiting, 2 at max, 3 met, 4 unmet, 5 empty, 6 muted, 7 dump ready
    typedef enum logic [3:0] {
        OC_NONE, OC_BUILD_PULSE, OC_DUMP_PULSE, OC_BYPASS, OC_CUE, OC_FLAG, OC_UTIL,
        OC_FULL_PULSE, OC_EMPTY_PULSE, OC_LAMP, OC_STATE
    } dugm_out_cls_t;
endpackage
